/* hw/acm_core.sv */
// Register bank and motion detection of a three-axis accelerometer.
// Assumes a decoded byte register port and raw/filtered samples from the front end.
`timescale 1ns/10ps
`default_nettype none
module acm_core #(
	parameter logic [7:0] MAKER_ID = 8'h5A, // Arbitrary value
	parameter logic [7:0] TRACE_ID = 8'h3C, // Arbitrary value
	parameter logic [7:0] PRODUCT_ID = 8'h96, // Arbitrary value
	parameter logic [7:0] REVISION = 8'h00,
	parameter int SEC_CYC = acm_pkg::SEC_CYCLES, // Cycles in one second
	parameter int RATE_DIV = 2000000 // Clock cycles per sample tick at reset rate
) (
	input wire logic clk,
	input wire logic rst,
	input wire acm_pkg::acm_req_type req, // Register access
	output logic [7:0] rdata, // Read data
	output logic rvalid, // Read data valid pulse
	input wire logic [7:0] trim_serial, // Serial from trim
	input wire acm_pkg::acm_sample_type raw, // Unfiltered sample
	input wire acm_pkg::acm_sample_type filt, // Filtered sample
	input wire logic i2c_start, // Start condition seen on bus
	input wire logic out_taken, // Host finished reading outputs
	output acm_pkg::acm_sample_type out_data, // Offset-corrected output
	output logic [3:0] rate_sel, // Rate field
	output logic low_power, // Reduced power
	output logic measuring, // Measurement mode
	output logic i2c_start_ok, // Start condition accepted
	output logic activity, // Activity event pulse
	output logic inactivity, // Inactivity event pulse
	output logic init_restart // Init routine restart pulse
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0] ofs_x;
		logic [7:0] ofs_y;
		logic [7:0] ofs_z;
		logic [7:0] act_thr;
		logic [7:0] inact_thr;
		logic [7:0] inact_dur;
		logic [7:0] ctl;
		logic [7:0] rate;
		logic [7:0] power;
		logic [7:0] rdata;
		logic rvalid;
		logic [31:0] tick_cnt;
		logic [31:0] sec_cnt;
		logic [7:0] below_secs;
		logic below_armed;
		logic have_sample;
		logic act_ref_ok;
		acm_pkg::acm_sample_type act_ref;
		acm_pkg::acm_sample_type inact_ref;
		acm_pkg::acm_link_type link_st;
		acm_pkg::acm_sample_type out_data;
		logic out_pending;
		logic dropped;
		logic i2c_ok;
		logic act_ev;
		logic inact_ev;
		logic init_p;
	} acm_state_type;
	acm_state_type s; // Registered state
	acm_state_type next_s; // Next state
	logic tick; // Sample tick
	logic [2:0] act_hit; // Per axis over threshold
	logic [2:0] inact_low; // Per axis below threshold
	logic [2:0] act_en; // Activity axis enables
	logic [2:0] inact_en; // Inactivity axis enables
	logic act_go; // Activity condition
	logic inact_below; // All participating axes below
	acm_pkg::acm_axis_type rv [3]; // Raw per axis
	acm_pkg::acm_axis_type fv [3]; // Filtered per axis
	acm_pkg::acm_axis_type ar [3]; // Activity reference
	acm_pkg::acm_axis_type ir [3]; // Inactivity reference
	acm_pkg::acm_axis_type ov [3]; // Output with offset
	logic [7:0] ofs [3]; // Offset per axis
	assign rv = '{raw.x, raw.y, raw.z};
	assign fv = '{filt.x, filt.y, filt.z};
	assign ar = '{s.act_ref.x, s.act_ref.y, s.act_ref.z};
	assign ir = '{s.inact_ref.x, s.inact_ref.y, s.inact_ref.z};
	assign ofs = '{s.ofs_x, s.ofs_y, s.ofs_z};
	// Enable fields hold x in their top bit; index 0 of the axis arrays is x
	assign act_en = {s.ctl[acm_pkg::CTL_ACT_AXIS], s.ctl[acm_pkg::CTL_ACT_AXIS + 1],
		s.ctl[acm_pkg::CTL_ACT_AXIS + 2]};
	assign inact_en = {s.ctl[acm_pkg::CTL_INACT_AXIS], s.ctl[acm_pkg::CTL_INACT_AXIS + 1],
		s.ctl[acm_pkg::CTL_INACT_AXIS + 2]};
	assign tick = s.tick_cnt == 32'(RATE_DIV - 1);
	// ------------------------------------------------------------
	// Per-axis compare and offset add
	// ------------------------------------------------------------
	for (genvar i = 0; i < 3; i++)
	begin : g_axis
		logic signed [16:0] ad; // Activity difference
		logic signed [16:0] id; // Inactivity difference
		logic [16:0] am; // Activity magnitude
		logic [16:0] im; // Inactivity magnitude
		logic [16:0] ath; // Activity threshold in data LSB
		logic [16:0] ith; // Inactivity threshold in data LSB
		// AC uses reference difference, DC the value itself
		assign ad = s.ctl[acm_pkg::CTL_ACT_AC] ? 17'(rv[i]) - 17'(ar[i]) : 17'(rv[i]);
		assign id = s.ctl[acm_pkg::CTL_INACT_AC] ? 17'(fv[i]) - 17'(ir[i]) : 17'(fv[i]);
		assign am = ad[16] ? 17'(-ad) : 17'(ad);
		assign im = id[16] ? 17'(-id) : 17'(id);
		assign ath = 17'(s.act_thr) << acm_pkg::THR_SHIFT;
		assign ith = 17'(s.inact_thr) << acm_pkg::THR_SHIFT;
		assign act_hit[i] = act_en[i] && am > ath;
		assign inact_low[i] = !inact_en[i] || im < ith;
		// Signed offset scaled into data LSB
		assign ov[i] = rv[i] + 16'(signed'({{8{ofs[i][7]}}, ofs[i]}) <<< acm_pkg::OFS_SHIFT);
	end
	assign act_go = |act_hit;
	assign inact_below = (|inact_en) && (&inact_low);
	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	always_comb
	begin
		logic act_on;
		logic inact_on;
		logic inact_fire;
		act_on = 1'b0;
		inact_on = 1'b0;
		inact_fire = 1'b0;
		next_s = s;
		next_s.rvalid = 1'b0;
		next_s.act_ev = 1'b0;
		next_s.inact_ev = 1'b0;
		next_s.init_p = 1'b0;
		// Start conditions only pass when bus not disabled
		next_s.i2c_ok = i2c_start && !s.power[acm_pkg::POW_I2C_OFF];
		// Free-running rate divider
		next_s.tick_cnt = tick ? 32'h0 : s.tick_cnt + 32'h1;
		// Register reads
		if (req.rd)
		begin
			next_s.rvalid = 1'b1;
			case (req.addr)
				acm_pkg::ADDR_MAKER: next_s.rdata = MAKER_ID;
				acm_pkg::ADDR_TRACE: next_s.rdata = TRACE_ID;
				acm_pkg::ADDR_PRODUCT: next_s.rdata = PRODUCT_ID;
				acm_pkg::ADDR_REV: next_s.rdata = REVISION;
				acm_pkg::ADDR_SERIAL: next_s.rdata = trim_serial;
				acm_pkg::ADDR_OFS_X: next_s.rdata = s.ofs_x;
				acm_pkg::ADDR_OFS_Y: next_s.rdata = s.ofs_y;
				acm_pkg::ADDR_OFS_Z: next_s.rdata = s.ofs_z;
				acm_pkg::ADDR_ACT_THR: next_s.rdata = s.act_thr;
				acm_pkg::ADDR_INACT_THR: next_s.rdata = s.inact_thr;
				acm_pkg::ADDR_INACT_DUR: next_s.rdata = s.inact_dur;
				acm_pkg::ADDR_MOTION_CTL: next_s.rdata = s.ctl;
				acm_pkg::ADDR_RATE: next_s.rdata = s.rate;
				acm_pkg::ADDR_POWER: next_s.rdata = s.power;
				default: next_s.rdata = 8'h00;
			endcase
		end
		// Motion detection on each sample tick while measuring
		// Linking only applies with both functions enabled
		act_on = |act_en && (!(s.power[acm_pkg::POW_LINK] && |inact_en)
			|| s.link_st == acm_pkg::LNK_WAIT_ACT);
		inact_on = |inact_en && (!(s.power[acm_pkg::POW_LINK] && |act_en)
			|| s.link_st == acm_pkg::LNK_WAIT_INACT);
		// Readout clears pending first, so a sample landing in the same cycle stays pending
		if (out_taken)
			next_s.out_pending = 1'b0;
		if (s.power[acm_pkg::POW_MEASURE] && tick)
		begin
			next_s.have_sample = 1'b1;
			// Output register update, excess samples dropped
			if (s.out_pending && !out_taken)
				next_s.dropped = 1'b1;
			else
			begin
				next_s.out_data = '{ov[0], ov[1], ov[2]};
				next_s.out_pending = 1'b1;
			end
			// Activity with reference capture at detection start
			if (act_on)
			begin
				if (s.ctl[acm_pkg::CTL_ACT_AC] && !s.act_ref_ok)
				begin
					next_s.act_ref = raw;
					next_s.act_ref_ok = 1'b1;
				end
				else if (act_go)
				begin
					next_s.act_ev = 1'b1;
					next_s.act_ref_ok = 1'b0;
					next_s.link_st = acm_pkg::LNK_WAIT_INACT;
				end
			end
			else
				next_s.act_ref_ok = 1'b0;
			// Inactivity timing in whole seconds
			if (inact_on && s.have_sample)
			begin
				if (!inact_below)
				begin
					next_s.below_armed = 1'b0;
					next_s.below_secs = 8'h00;
					next_s.sec_cnt = 32'h0;
					next_s.inact_ref = filt;
				end
				else
				begin
					next_s.below_armed = 1'b1;
					if (s.below_secs >= s.inact_dur)
						inact_fire = 1'b1;
				end
			end
		end
		// Second counter runs while all participating axes stay below
		if (s.below_armed && inact_on && !inact_fire)
		begin
			if (s.sec_cnt == 32'(SEC_CYC - 1))
			begin
				next_s.sec_cnt = 32'h0;
				if (s.below_secs != 8'hFF)
					next_s.below_secs = s.below_secs + 8'h01;
			end
			else
				next_s.sec_cnt = s.sec_cnt + 32'h1;
		end
		if (inact_fire)
		begin
			next_s.inact_ev = 1'b1;
			next_s.below_armed = 1'b0;
			next_s.below_secs = 8'h00;
			next_s.sec_cnt = 32'h0;
			next_s.link_st = acm_pkg::LNK_WAIT_ACT;
		end
		if (!s.power[acm_pkg::POW_MEASURE])
		begin
			next_s.have_sample = 1'b0;
			next_s.below_armed = 1'b0;
			next_s.below_secs = 8'h00;
			next_s.act_ref_ok = 1'b0;
		end
		// Register writes
		if (req.wr)
		begin
			case (req.addr)
				acm_pkg::ADDR_RESET_KEY:
					if (req.wdata == acm_pkg::RESET_KEY)
					begin
						next_s = '0;
						next_s.rate = acm_pkg::RATE_RESET;
						next_s.link_st = acm_pkg::LNK_WAIT_INACT;
						next_s.init_p = 1'b1;
					end
				acm_pkg::ADDR_OFS_X: next_s.ofs_x = req.wdata;
				acm_pkg::ADDR_OFS_Y: next_s.ofs_y = req.wdata;
				acm_pkg::ADDR_OFS_Z: next_s.ofs_z = req.wdata;
				acm_pkg::ADDR_ACT_THR: next_s.act_thr = req.wdata;
				acm_pkg::ADDR_INACT_THR: next_s.inact_thr = req.wdata;
				acm_pkg::ADDR_INACT_DUR: next_s.inact_dur = req.wdata;
				acm_pkg::ADDR_MOTION_CTL: next_s.ctl = req.wdata;
				acm_pkg::ADDR_RATE: next_s.rate = req.wdata & acm_pkg::RATE_MASK;
				acm_pkg::ADDR_POWER: next_s.power = req.wdata & acm_pkg::POWER_MASK;
				default: next_s.init_p = s.init_p & 1'b0;
			endcase
		end
	end
	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			s <= '0;
			s.rate <= acm_pkg::RATE_RESET;
			// Linked mode holds activity back until inactivity is seen
			s.link_st <= acm_pkg::LNK_WAIT_INACT;
		end
		else
			s <= next_s;
	end
	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign rdata = s.rdata;
	assign rvalid = s.rvalid;
	assign out_data = s.out_data;
	assign rate_sel = s.rate[3:0];
	assign low_power = s.rate[acm_pkg::RATE_LOWPWR];
	assign measuring = s.power[acm_pkg::POW_MEASURE];
	assign i2c_start_ok = s.i2c_ok;
	assign activity = s.act_ev;
	assign inactivity = s.inact_ev;
	assign init_restart = s.init_p;
	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_key_reset: assert property (@(posedge clk) disable iff (rst)
		(req.wr && req.addr == acm_pkg::ADDR_RESET_KEY && req.wdata == acm_pkg::RESET_KEY)
		|=> init_restart && s.act_thr == 8'h00 && rate_sel == 4'hA)
		else $error("key write did not clear configuration");
	a_i2c_block: assert property (@(posedge clk) disable iff (rst)
		$past(s.power[acm_pkg::POW_I2C_OFF]) |-> !i2c_start_ok)
		else $error("start accepted while bus disabled");
	a_ident_read: assert property (@(posedge clk) disable iff (rst)
		(req.rd && req.addr == acm_pkg::ADDR_MAKER) |=> rvalid && rdata == MAKER_ID)
		else $error("maker read wrong");
	a_standby_quiet: assert property (@(posedge clk) disable iff (rst)
		!$past(measuring) && !$past(req.wr) |-> !activity && !inactivity)
		else $error("event in standby");
	a_act_gate: assert property (@(posedge clk) disable iff (rst)
		activity |-> $past(|act_en))
		else $error("activity with no axis");
	a_inact_gate: assert property (@(posedge clk) disable iff (rst)
		inactivity |-> $past(|inact_en))
		else $error("inactivity with no axis");
	a_link_order: assert property (@(posedge clk) disable iff (rst)
		(activity && s.power[acm_pkg::POW_LINK] && $stable(s.power)) |-> s.link_st == acm_pkg::LNK_WAIT_INACT)
		else $error("link state not advanced");
	a_drop_keep: assert property (@(posedge clk) disable iff (rst)
		(s.out_pending && !out_taken && tick && !req.wr) |=> $stable(out_data))
		else $error("pending output overwritten");
	// Activity only from a sample tick with an axis over threshold
	a_act_tick: assert property (@(posedge clk) disable iff (rst)
		activity |-> $past(act_go && tick))
		else $error("activity without qualifying tick");
	// Inactivity only from a sample tick with all participating axes below
	a_inact_tick: assert property (@(posedge clk) disable iff (rst)
		inactivity |-> $past(inact_below && tick))
		else $error("inactivity without quiet tick");
endmodule : acm_core
`default_nettype wire

/* hw/acm_pkg.sv */
// Constants and carrier types for the accelerometer configuration and motion block.
// Assumes a register port already decoded from the serial interface, one byte per access.
// Behaviour
// - Three fixed read-only identity bytes at start.
// - Read-only silicon revision number register.
// - Read-only trim-derived serial number register.
// - Key write restarts init, clears configuration.
// - Three signed eight-bit axis offset trims.
// - Offset added to axis data into outputs.
// - Unsigned activity threshold compared against magnitude.
// - Unsigned inactivity threshold compared against magnitude.
// - Inactivity needs below-threshold for duration seconds.
// - Inactivity uses filtered data, needs one sample.
// - Zero duration: inactivity as soon as below.
// - Coupling bit zero compares magnitude directly.
// - AC activity compares against start reference.
// - AC inactivity reference refreshed on exceed.
// - Axis enables; all excluded disables function.
// - Activity ORs participating axes.
// - Inactivity ANDs participating axes.
// - Low-power bit selects reduced power operation.
// - Four-bit rate field, reset means 100 Hz.
// - Excess samples dropped, sampling never stalls.
// - Bus-disable bit makes I2C starts ignored.
// - Measure bit: standby or measurement, start standby.
// - Link bit serialises activity and inactivity.
package acm_pkg;
	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_MAKER = 8'h00;
	localparam logic [7:0] ADDR_TRACE = 8'h01;
	localparam logic [7:0] ADDR_PRODUCT = 8'h02;
	localparam logic [7:0] ADDR_REV = 8'h03;
	localparam logic [7:0] ADDR_SERIAL = 8'h04;
	localparam logic [7:0] ADDR_RESET_KEY = 8'h18;
	localparam logic [7:0] ADDR_OFS_X = 8'h1E;
	localparam logic [7:0] ADDR_OFS_Y = 8'h1F;
	localparam logic [7:0] ADDR_OFS_Z = 8'h20;
	localparam logic [7:0] ADDR_ACT_THR = 8'h24;
	localparam logic [7:0] ADDR_INACT_THR = 8'h25;
	localparam logic [7:0] ADDR_INACT_DUR = 8'h26;
	localparam logic [7:0] ADDR_MOTION_CTL = 8'h27;
	localparam logic [7:0] ADDR_RATE = 8'h2C;
	localparam logic [7:0] ADDR_POWER = 8'h2D;
	// ------------------------------------------------------------
	// Values and field layouts
	// ------------------------------------------------------------
	localparam logic [7:0] RESET_KEY = 8'h52;
	localparam logic [7:0] RATE_RESET = 8'h0A;
	localparam logic [7:0] RATE_MASK = 8'h1F;
	localparam logic [7:0] POWER_MASK = 8'h7F;
	localparam int POW_I2C_OFF = 6;
	localparam int POW_LINK = 5;
	localparam int POW_MEASURE = 3;
	localparam int RATE_LOWPWR = 4;
	localparam int CTL_ACT_AC = 7;
	localparam int CTL_ACT_AXIS = 4;
	localparam int CTL_INACT_AC = 3;
	localparam int CTL_INACT_AXIS = 0;
	// Threshold is 15.625 mg; data is 1024 LSB/g so one threshold LSB is 16 data LSB
	localparam int THR_SHIFT = 4;
	// Offset weight 3.9 mg is four data LSB
	localparam int OFS_SHIFT = 2;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_HZ = 200000000;
	localparam int SEC_PER_LSB = 1;
	localparam int SEC_CYCLES = CLK_HZ * SEC_PER_LSB;
	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} acm_req_type;
	typedef logic signed [15:0] acm_axis_type;
	typedef struct packed {
		acm_axis_type x;
		acm_axis_type y;
		acm_axis_type z;
	} acm_sample_type;
	typedef enum logic [0:0] {LNK_WAIT_ACT, LNK_WAIT_INACT} acm_link_type;
endpackage : acm_pkg

/* verification/acm_host_model.sv */
// Host-side model of the serial master: byte register accesses and output readout.
// Assumes the decoded register port of acm_core, driven at the falling clock edge.
`timescale 1ns/10ps
`default_nettype none
module acm_host_model (
	input wire logic clk,
	output var acm_pkg::acm_req_type req,
	input wire logic [7:0] rdata,
	input wire logic rvalid,
	output logic out_taken
);
	// ------------------------------------------------------------
	// Idle bus, outputs read out at once
	// ------------------------------------------------------------
	initial
	begin
		req = '0;
		out_taken = 1'b1;
	end
	// Host readiness for output data; low leaves the sample pending
	task automatic take(input logic t);
		@(negedge clk);
		out_taken = t;
	endtask : take
	// One-cycle write strobe, then idle
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge clk);
		req = '0;
	endtask : wr
	// One-cycle read strobe, data taken with the valid pulse
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(negedge clk);
		req = '0;
		d = 8'hXX;
		repeat (4)
		begin
			if (rvalid === 1'b1)
			begin
				d = rdata;
				break;
			end
			@(negedge clk);
		end
	endtask : rd
endmodule : acm_host_model
`default_nettype wire

/* verification/test_accel_config_and_motion_detect.sv */
// Self-checking bench of the accelerometer register bank and motion detection.
// Assumes acm_core with short tick and second counts; host model in its own file.
`timescale 1ns/10ps
`default_nettype none
module test_accel_config_and_motion_detect;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	localparam logic [7:0] MK = 8'h5A; // Arbitrary value
	localparam logic [7:0] TR = 8'h3C; // Arbitrary value
	localparam logic [7:0] PR = 8'h96; // Arbitrary value
	logic clk, rst, rvalid, i2c_start, out_taken, low_power, measuring;
	logic i2c_start_ok, activity, inactivity, init_restart, hit;
	logic [7:0] rdata, trim_serial, d;
	logic [3:0] rate_sel;
	acm_pkg::acm_req_type req;
	acm_pkg::acm_sample_type raw, filt, out_data;
	int n_fail, tests_run, cycles;
	typedef struct {logic [7:0] a, rv, wv, ev;} acm_row_type;
	acm_row_type rows [15] = '{
		'{8'h00, MK, 8'hFF, MK}, '{8'h01, TR, 8'hFF, TR}, '{8'h02, PR, 8'hFF, PR},
		'{8'h03, 8'h00, 8'hFF, 8'h00}, '{8'h04, 8'h6E, 8'hFF, 8'h6E},
		'{8'h05, 8'h00, 8'h77, 8'h00}, '{8'h1E, 8'h00, 8'h7F, 8'h7F},
		'{8'h1F, 8'h00, 8'h80, 8'h80}, '{8'h20, 8'h00, 8'h01, 8'h01},
		'{8'h24, 8'h00, 8'h02, 8'h02}, '{8'h25, 8'h00, 8'h02, 8'h02},
		'{8'h26, 8'h00, 8'h01, 8'h01}, '{8'h27, 8'h00, 8'h40, 8'h40},
		'{8'h2C, 8'h0A, 8'hFF, 8'h1F}, '{8'h2D, 8'h00, 8'hC8, 8'h48}};
	// ------------------------------------------------------------
	// Design and host
	// ------------------------------------------------------------
	acm_core #(.MAKER_ID(MK), .TRACE_ID(TR), .PRODUCT_ID(PR), .SEC_CYC(50), .RATE_DIV(10))
	i_acm_core (.clk(clk), .rst(rst), .req(req), .rdata(rdata), .rvalid(rvalid),
		.trim_serial(trim_serial), .raw(raw), .filt(filt), .i2c_start(i2c_start),
		.out_taken(out_taken), .out_data(out_data), .rate_sel(rate_sel),
		.low_power(low_power), .measuring(measuring), .i2c_start_ok(i2c_start_ok),
		.activity(activity), .inactivity(inactivity), .init_restart(init_restart));
	acm_host_model i_acm_host_model (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid),
		.out_taken(out_taken));
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Compare and count
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	// Watch an event pulse for n cycles; sel high watches inactivity
	task automatic watch(input logic sel, input int n, output logic h);
		h = 1'b0;
		repeat (n)
		begin
			@(negedge clk);
			if ((sel ? inactivity : activity) === 1'b1)
				h = 1'b1;
		end
	endtask : watch
	// Verdict and end of run
	task automatic final_report;
		if (n_fail == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : final_report
	// Clock, 5 ns period
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// Hang guard
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_fail++;
			final_report();
		end
	end
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		n_fail = 0;
		tests_run = 0;
		cycles = 0;
		rst = 1'b1;
		i2c_start = 1'b0;
		trim_serial = 8'h6E;
		raw = '0;
		filt = '0;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		// Reset values, then write and read back every row
		foreach (rows[i])
		begin
			i_acm_host_model.rd(rows[i].a, d);
			check({8'h00, d}, {8'h00, rows[i].rv});
		end
		foreach (rows[i])
		begin
			i_acm_host_model.wr(rows[i].a, rows[i].wv);
			i_acm_host_model.rd(rows[i].a, d);
			check({8'h00, d}, {8'h00, rows[i].ev});
		end
		check({low_power, measuring, rate_sel}, 6'h3F);
		// Start conditions ignored, then accepted
		@(negedge clk) i2c_start = 1'b1;
		@(negedge clk) i2c_start = 1'b0;
		check(i2c_start_ok, 1'b0);
		i_acm_host_model.wr(8'h2D, 8'h08);
		@(negedge clk) i2c_start = 1'b1;
		@(negedge clk) i2c_start = 1'b0;
		check(i2c_start_ok, 1'b1);
		// Offset of extreme x and y trims and a one-step z trim added to data
		raw = '{x: 16'sd100, y: 16'sd100, z: -16'sd5};
		repeat (25) @(negedge clk);
		check(out_data.x, 16'd608);
		check(out_data.y, 16'hFE64);
		check(out_data.z, 16'hFFFF);
		// Wrong key keeps config, right key clears it
		i_acm_host_model.wr(8'h18, 8'h51);
		i_acm_host_model.rd(8'h1E, d);
		check(d, 8'h7F);
		i_acm_host_model.wr(8'h18, 8'h52);
		check(init_restart, 1'b1);
		i_acm_host_model.rd(8'h1E, d);
		check(d, 8'h00);
		i_acm_host_model.rd(8'h2C, d);
		check({d, 7'h00, measuring}, 16'h0A00);
		// Activity on x only, dc coupled
		raw = '{x: 16'sd20, y: 16'sd200, z: 16'sd0};
		i_acm_host_model.wr(8'h24, 8'h02);
		i_acm_host_model.wr(8'h27, 8'h40);
		i_acm_host_model.wr(8'h2D, 8'h08);
		watch(1'b0, 40, hit);
		check(hit, 1'b0);
		raw.x = -16'sd40;
		watch(1'b0, 30, hit);
		check(hit, 1'b1);
		// Inactivity on all axes after one second
		raw = '0;
		i_acm_host_model.wr(8'h25, 8'h02);
		i_acm_host_model.wr(8'h26, 8'h01);
		i_acm_host_model.wr(8'h27, 8'h07);
		watch(1'b1, 35, hit);
		check(hit, 1'b0);
		watch(1'b1, 60, hit);
		check(hit, 1'b1);
		// One busy axis blocks inactivity
		filt.z = 16'sd100;
		i_acm_host_model.wr(8'h26, 8'h00);
		repeat (15) @(negedge clk);
		watch(1'b1, 60, hit);
		check(hit, 1'b0);
		// Zero duration fires at once when quiet
		filt.z = 16'sd0;
		watch(1'b1, 30, hit);
		check(hit, 1'b1);
		// Linked: activity held back until inactivity, then follows it
		i_acm_host_model.wr(8'h18, 8'h52);
		raw.x = -16'sd40;
		filt.x = 16'sd100;
		i_acm_host_model.wr(8'h24, 8'h02);
		i_acm_host_model.wr(8'h25, 8'h02);
		i_acm_host_model.wr(8'h27, 8'h47);
		i_acm_host_model.wr(8'h2D, 8'h28);
		watch(1'b0, 40, hit);
		check(hit, 1'b0);
		filt.x = 16'sd0;
		watch(1'b1, 30, hit);
		check(hit, 1'b1);
		watch(1'b0, 30, hit);
		check(hit, 1'b1);
		// Unread sample kept, later ones dropped
		i_acm_host_model.take(1'b0);
		repeat (15) @(negedge clk);
		raw.x = 16'sd7;
		repeat (25) @(negedge clk);
		check(out_data.x, 16'hFFD8);
		i_acm_host_model.take(1'b1);
		repeat (15) @(negedge clk);
		check(out_data.x, 16'h0007);
		// AC activity ignores a steady level, sees a change
		i_acm_host_model.wr(8'h2D, 8'h08);
		raw.x = 16'sd100;
		i_acm_host_model.wr(8'h27, 8'hC0);
		watch(1'b0, 30, hit);
		check(hit, 1'b0);
		raw.x = 16'sd60;
		watch(1'b0, 30, hit);
		check(hit, 1'b1);
		// AC inactivity settles on a steady offset level
		filt.x = 16'sd200;
		i_acm_host_model.wr(8'h27, 8'h0F);
		watch(1'b1, 40, hit);
		check(hit, 1'b1);
		final_report();
	end
endmodule : test_accel_config_and_motion_detect
`default_nettype wire
